// ---- hw/vic_top.sv ----
// vectored interrupt controller: edge capture, masking, priority, vector, apb registers
//
// Behaviour
// R1: six requests, each maskable, each in priority resolution.
// R2: sources: three falling pin edges, one rising edge, two timers.
// R3: mask register has global enable and per-request enables; off blocks.
// R4: priority register steers a programmable encoder among pending requests.
// R5: each request has its own program-memory vector location.
// R6: a grant clears the global enable until software sets it again.
// R7: core saves pc and flags, then branches to the granted vector.
// R8: vector location and next byte give the 16-bit handler address.
// R9: masked requests still recorded so software can poll them.
// R10: request zero: falling second comparator pin, vector bytes 0,1.
// R11: request one: falling reference pin, vector bytes 2,3.
// R12: request two: falling first comparator pin, vector bytes 4,5.
// R13: request three: rising second comparator pin, vector bytes 6,7.
// R14: request four: counter/timer zero, vector bytes 8,9.
// R15: request five: counter/timer one, vector bytes 10,11.
// R16: priority write-only at F9; request and mask read/write at FA, FB.
// R17: events set request bits regardless of mask; grant clears; software writes.
// R18: pins synchronised and compared with previous sample, one set per edge.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module vic_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [vic_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [vic_pkg::DATA_W-1:0] pwdata,
    output logic [vic_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic ext_irq_pin_c,
    input wire logic counter_timer_zero_evt,
    input wire logic counter_timer_one_evt,
    input wire logic core_ack,
    output logic core_irq,
    output vic_pkg::vic_vector_s vector,
    output logic vector_valid,
    output logic irq
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic vic_hit(input logic [vic_pkg::ADDR_W-1:0] a,
                                     input logic [7:0] idx);
        logic [vic_pkg::ADDR_W-1:0] b;
        b = vic_pkg::ADDR_W'({idx, 2'h0});
        return a == b;
    endfunction

    // first pending request walking from the start index in the chosen direction
    function automatic logic [3:0] vic_pick(input logic [5:0] pend,
                                            input logic [7:0] prio);
        logic [3:0] res;
        int s;
        int c;
        res = 4'h0;
        s = int'(prio[vic_pkg::PRIO_START_W-1:0]) % vic_pkg::NUM_REQ;
        c = 0;
        for (int k = vic_pkg::NUM_REQ - 1; k >= 0; k--) begin
            if (prio[vic_pkg::PRIO_DIR_BIT]) begin
                c = (s - k + vic_pkg::NUM_REQ) % vic_pkg::NUM_REQ;
            end else begin
                c = (s + k) % vic_pkg::NUM_REQ;
            end
            if (pend[c]) begin
                res = {1'b1, 3'(c)};
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    vic_pkg::vic_state_s r;
    vic_pkg::vic_state_s next_r;
    logic [2:0] fall;
    logic [2:0] rise;
    logic [5:0] hw_set;
    logic [5:0] eligible;
    logic [3:0] win;
    logic grant;
    logic wr;
    logic rd_setup;
    logic mapped;
    logic [15:0] win_addr;

    // ------------------------------------------------------------------
    // request capture
    // ------------------------------------------------------------------
    always_comb begin
        fall = r.prev & ~r.sync2; // R18
        rise = ~r.prev & r.sync2; // R18
        hw_set = 6'h00;
        hw_set[0] = fall[vic_pkg::PIN_B]; // R10
        hw_set[1] = fall[vic_pkg::PIN_C]; // R11
        hw_set[2] = fall[vic_pkg::PIN_A]; // R12
        hw_set[3] = rise[vic_pkg::PIN_B]; // R13
        hw_set[4] = counter_timer_zero_evt; // R14
        hw_set[5] = counter_timer_one_evt; // R15
    end

    // ------------------------------------------------------------------
    // masking and priority
    // ------------------------------------------------------------------
    // a request only competes when its own enable and the global enable are on
    assign eligible = r.req & r.mask[vic_pkg::NUM_REQ-1:0]
                      & {vic_pkg::NUM_REQ{r.mask[vic_pkg::GLOBAL_EN_BIT]}}; // R3 R1
    assign win = vic_pick(eligible, r.prio); // R4
    // vector bytes sit at twice the request number
    assign win_addr = 16'(win[2:0]) * 16'(vic_pkg::VEC_STRIDE); // R5
    assign core_irq = win[3] && (r.gstate == vic_pkg::VIC_IDLE);
    assign grant = core_ack && core_irq;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped = vic_hit(paddr, vic_pkg::PRIO_IDX)
                    || vic_hit(paddr, vic_pkg::REQ_IDX)
                    || vic_hit(paddr, vic_pkg::MASK_IDX)
                    || vic_hit(paddr, vic_pkg::EVT_STAT_IDX)
                    || vic_hit(paddr, vic_pkg::EVT_MASK_IDX); // R16
    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = r.prdata;
    assign vector = r.vec;
    assign vector_valid = (r.gstate == vic_pkg::VIC_VEC);
    assign irq = |(r.evt_stat & r.evt_mask);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.sync1 = {ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a}; // R18
        next_r.sync2 = r.sync1;
        next_r.prev = r.sync2;
        if (wr && vic_hit(paddr, vic_pkg::PRIO_IDX)) begin
            next_r.prio = pwdata[vic_pkg::REG_W-1:0]; // R16
        end
        if (wr && vic_hit(paddr, vic_pkg::REQ_IDX)) begin
            next_r.req = pwdata[vic_pkg::NUM_REQ-1:0]; // R17
        end
        if (wr && vic_hit(paddr, vic_pkg::MASK_IDX)) begin
            next_r.mask = pwdata[vic_pkg::REG_W-1:0]; // R3
        end
        if (wr && vic_hit(paddr, vic_pkg::EVT_MASK_IDX)) begin
            next_r.evt_mask = pwdata[vic_pkg::NUM_REQ-1:0];
        end
        if (wr && vic_hit(paddr, vic_pkg::EVT_STAT_IDX)) begin
            next_r.evt_stat = r.evt_stat & ~pwdata[vic_pkg::NUM_REQ-1:0];
        end
        if (grant) begin
            next_r.req[win[2:0]] = 1'b0; // R17
            // grant beats a same-cycle software write of the global enable
            next_r.mask[vic_pkg::GLOBAL_EN_BIT] = 1'b0; // R6
            next_r.vec.lo_addr = win_addr; // R5 R7
            next_r.vec.hi_addr = win_addr + 16'h0001; // R8
            next_r.vec.id = win[2:0];
        end
        // sets are applied last so an event never loses to a clear
        next_r.req = next_r.req | hw_set; // R9 R17 R2
        next_r.evt_stat = next_r.evt_stat | hw_set;
        if (rd_setup) begin
            next_r.prdata = 32'h0000_0000;
            if (vic_hit(paddr, vic_pkg::REQ_IDX)) begin
                next_r.prdata = 32'(r.req); // R9
            end
            if (vic_hit(paddr, vic_pkg::MASK_IDX)) begin
                next_r.prdata = 32'(r.mask);
            end
            if (vic_hit(paddr, vic_pkg::EVT_STAT_IDX)) begin
                next_r.prdata = 32'(r.evt_stat);
            end
            if (vic_hit(paddr, vic_pkg::EVT_MASK_IDX)) begin
                next_r.prdata = 32'(r.evt_mask);
            end
        end
        unique case (r.gstate)
            vic_pkg::VIC_IDLE: begin
                if (grant) begin
                    next_r.gstate = vic_pkg::VIC_VEC; // R7
                end
            end
            vic_pkg::VIC_VEC: begin
                next_r.gstate = vic_pkg::VIC_HOLD;
            end
            vic_pkg::VIC_HOLD: begin
                // a held acknowledge must not grant twice
                if (!core_ack) begin
                    next_r.gstate = vic_pkg::VIC_IDLE;
                end
            end
            default: begin
                next_r.gstate = vic_pkg::VIC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // pins assumed idle high so a released reset makes no false edge
            r.sync1 <= vic_pkg::PIN_RST;
            r.sync2 <= vic_pkg::PIN_RST;
            r.prev <= vic_pkg::PIN_RST;
            r.prio <= vic_pkg::PRIO_RST;
            r.req <= vic_pkg::REQ_RST;
            r.mask <= vic_pkg::MASK_RST;
            r.evt_stat <= vic_pkg::EVT_RST;
            r.evt_mask <= vic_pkg::EVT_RST;
            r.prdata <= 32'h0000_0000;
            r.vec <= '0;
            r.gstate <= vic_pkg::VIC_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_grant_clears_req: assert property ( // R17
        @(posedge pclk) disable iff (!presetn)
        grant && !hw_set[win[2:0]] |=> !r.req[$past(win[2:0])])
        else $error("granted request bit not cleared");

    a_grant_disables_all: assert property ( // R6
        @(posedge pclk) disable iff (!presetn)
        grant |=> !r.mask[vic_pkg::GLOBAL_EN_BIT] && !core_irq)
        else $error("global enable still on after grant");

    a_vector_addr_pair: assert property ( // R8
        @(posedge pclk) disable iff (!presetn)
        grant |=> vector.lo_addr == 16'($past(win[2:0])) * 16'h0002
                  && vector.hi_addr == vector.lo_addr + 16'h0001)
        else $error("vector address pair wrong");

    a_vector_one_pulse: assert property ( // R7
        @(posedge pclk) disable iff (!presetn)
        grant |=> vector_valid ##1 !vector_valid)
        else $error("vector valid not a single pulse");

    a_masked_no_irq: assert property ( // R3
        @(posedge pclk) disable iff (!presetn)
        !r.mask[vic_pkg::GLOBAL_EN_BIT] |-> !core_irq)
        else $error("request offered while globally disabled");

    a_winner_eligible: assert property ( // R4
        @(posedge pclk) disable iff (!presetn)
        core_irq |-> eligible[win[2:0]] && r.mask[win[2:0]])
        else $error("winner is not an enabled pending request");

    a_event_sets_req: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        |hw_set |=> (r.req & $past(hw_set)) == $past(hw_set))
        else $error("event did not set its request bit");

    a_fall_detect_b: assert property ( // R10
        @(posedge pclk) disable iff (!presetn)
        $fell(ext_irq_pin_b) ##1 !ext_irq_pin_b |-> ##1 hw_set[0] ##1 !hw_set[0])
        else $error("falling edge not seen exactly once");

    a_status_w1c: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && vic_hit(paddr, vic_pkg::EVT_STAT_IDX) && pwdata[0] && !hw_set[0]
        |=> !r.evt_stat[0])
        else $error("write one did not clear status");
endmodule
`default_nettype wire

// ---- hw/vic_pkg.sv ----
// constants, field layouts and carrier types of the vectored interrupt controller
package vic_pkg;
    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_REQ = 6;
    localparam int NUM_PIN = 3;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] PRIO_IDX = 8'hF9;
    localparam logic [7:0] REQ_IDX = 8'hFA;
    localparam logic [7:0] MASK_IDX = 8'hFB;
    localparam logic [7:0] EVT_STAT_IDX = 8'hE0;
    localparam logic [7:0] EVT_MASK_IDX = 8'hE1;
    localparam int IDX_SHIFT = 2;
    // ------------------------------------------------------------------
    // fields
    // ------------------------------------------------------------------
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PRIO_START_W = 3;
    localparam int PRIO_DIR_BIT = 3;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int VEC_STRIDE = 2;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [5:0] REQ_RST = 6'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [5:0] EVT_RST = 6'h00;
    localparam logic [2:0] PIN_RST = 3'h7;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        VIC_IDLE = 2'h0,
        VIC_VEC = 2'h1,
        VIC_HOLD = 2'h3
    } vic_gstate_e;
    typedef struct packed {
        logic [15:0] lo_addr;
        logic [15:0] hi_addr;
        logic [2:0] id;
    } vic_vector_s;
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] prev;
        logic [7:0] prio;
        logic [5:0] req;
        logic [7:0] mask;
        logic [5:0] evt_stat;
        logic [5:0] evt_mask;
        logic [31:0] prdata;
        vic_vector_s vec;
        vic_gstate_e gstate;
    } vic_state_s;
endpackage

// ---- testbench/vic_core_model.sv ----
// processor core sequencer model facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_irq,
    input wire vic_pkg::vic_vector_s vector,
    input wire logic vector_valid,
    output logic core_ack,
    output logic [7:0] grant_count
);
    // ------------------------------------------------------------------
    // interrupt machine cycle
    // ------------------------------------------------------------------
    // ack lags the request by a cycle, as the core finishes its instruction first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ack <= 1'b0;
            grant_count <= 8'h00;
        end else begin
            core_ack <= core_irq;
            if (vector_valid && vector.hi_addr == vector.lo_addr + 16'h0001) begin
                grant_count <= grant_count + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/test_vic_top.sv ----
// self-checking bench of the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module test_vic_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pin_a, pin_b, pin_c, t0, t1, core_ack, core_irq, vector_valid, irq;
    logic [7:0] grant_count;
    vic_pkg::vic_vector_s vector;
    int n_mismatch, check_count;

    vic_top i_vic_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
        .ext_irq_pin_c(pin_c), .counter_timer_zero_evt(t0), .counter_timer_one_evt(t1),
        .core_ack(core_ack), .core_irq(core_irq), .vector(vector),
        .vector_valid(vector_valid), .irq(irq));
    vic_core_model i_vic_core_model (.pclk(pclk), .presetn(presetn), .core_irq(core_irq),
        .vector(vector), .vector_valid(vector_valid), .core_ack(core_ack),
        .grant_count(grant_count));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // the request is held until pready is seen high, whatever the slave's latency
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no wait-state limit here: only the watchdog ends a stuck transfer
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    task wait_grant(input logic [2:0] id);
        int n;
        n = 0;
        @(posedge pclk);
        while (vector_valid !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        // a stale vector from the last grant could otherwise match
        chk({31'h0, vector_valid}, 32'h1);
        chk({29'h0, vector.id}, {29'h0, id});
        chk({16'h0, vector.lo_addr}, {28'h0, id, 1'b0});
        chk({16'h0, vector.hi_addr}, {28'h0, id, 1'b1});
    endtask
    task fire(input int i);
        @(posedge pclk);
        case (i)
            0: pin_b <= 1'b0;
            1: pin_c <= 1'b0;
            2: pin_a <= 1'b0;
            3: pin_b <= 1'b1;
            4: t0 <= 1'b1;
            default: t1 <= 1'b1;
        endcase
        @(posedge pclk);
        t0 <= 1'b0;
        t1 <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    task end_of_test;
        $display("counts: checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, t0, t1, presetn} = 6'h00;
        {pin_a, pin_b, pin_c} = 3'h7;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        chk({27'h0, pready, pslverr, core_irq, vector_valid, irq}, 32'h10);
        chk(prdata, 32'h0);
        presetn <= 1'b1;
        rdchk(vic_pkg::REQ_IDX, 32'h0);
        rdchk(vic_pkg::MASK_IDX, 32'h0);
        apb(1'b1, vic_pkg::PRIO_IDX, 32'h05);
        rdchk(vic_pkg::PRIO_IDX, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            fire(i);
            rdchk(vic_pkg::REQ_IDX, 32'h1 << i);
            chk({31'h0, core_irq}, 32'h0);
            apb(1'b1, vic_pkg::REQ_IDX, 32'h0);
        end
        pin_a <= 1'b1;
        pin_c <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(vic_pkg::REQ_IDX, 32'h0);
        $display("test polled sources done");
        rdchk(vic_pkg::EVT_STAT_IDX, 32'h3F);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, vic_pkg::EVT_MASK_IDX, 32'h10);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, vic_pkg::EVT_STAT_IDX, 32'h11);
        rdchk(vic_pkg::EVT_STAT_IDX, 32'h2E);
        chk({31'h0, irq}, 32'h0);
        $display("test event line done");
        apb(1'b1, vic_pkg::PRIO_IDX, 32'h00);
        apb(1'b1, vic_pkg::REQ_IDX, 32'h3F);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, vic_pkg::MASK_IDX, 32'hBF);
            wait_grant(3'(k));
            rdchk(vic_pkg::MASK_IDX, 32'h3F);
        end
        chk({24'h0, grant_count}, 32'h6);
        apb(1'b1, vic_pkg::PRIO_IDX, 32'h0B);
        apb(1'b1, vic_pkg::REQ_IDX, 32'h3F);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, vic_pkg::MASK_IDX, 32'hBF);
            wait_grant(3'((9 - k) % 6));
        end
        $display("test priority done");
        apb(1'b1, vic_pkg::REQ_IDX, 32'h3F);
        apb(1'b1, vic_pkg::MASK_IDX, 32'h3F);
        repeat (5) @(posedge pclk);
        chk({31'h0, core_irq}, 32'h0);
        apb(1'b1, vic_pkg::MASK_IDX, 32'h90);
        wait_grant(3'h4);
        rdchk(vic_pkg::REQ_IDX, 32'h2F);
        $display("test masking done");
        // mid-run reset with requests pending and the grant machine back in idle
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({27'h0, pready, pslverr, core_irq, vector_valid, irq}, 32'h10);
        presetn <= 1'b1;
        rdchk(vic_pkg::REQ_IDX, 32'h0);
        rdchk(vic_pkg::MASK_IDX, 32'h0);
        rdchk(vic_pkg::EVT_STAT_IDX, 32'h0);
        $display("test reset done");
        end_of_test();
    end
    // a run needs some two hundred forty cycles; hang cut well beyond it
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
